// ---- dv/power_button_sequencer_checker.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module power_button_sequencer_checker #(
  parameter int DEBOUNCE_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push_button_input,
  input wire logic hold_on_input,
  input wire logic over_temp,
  input wire logic reset_sense_above,
  input wire pwr_seq_pkg::rail_in_s rails_in,
  input wire pwr_seq_pkg::rail_out_s rails_out,
  input wire logic [1:0] lockout_level,
  input wire logic power_good_output_oe_n,
  input wire logic reset_output_oe_n,
  input wire logic button_wake_output_oe_n,
  input wire logic external_regulator_enable
);
  import pwr_seq_pkg::*;
  int low_cnt;
  logic all_good;
  // mask stays at its default, so every rail counts
  assign all_good = &{rails_in.rail_good, rails_in.reg_good};
  // run length of a pressed button, bounds the debounce
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
    end else if (push_button_input) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_drop;
    $fell(hold_on_input) && push_button_input;
  endsequence
  sequence s_shut;
    ##[1:4] (rails_out.conv_on == 3'h0 && rails_out.reg_on == 2'h0);
  endsequence
  AST_LOCKOUT_DEFAULT: assert property ($fell(rst) |-> lockout_level == 2'h0)
    else $error("lockout level not at default");
  AST_WAKE_FLOAT: assert property (
    $rose(push_button_input) |-> ##[0:4] button_wake_output_oe_n)
    else $error("wake output not released");
  AST_WAKE_DEBOUNCE: assert property (
    $fell(button_wake_output_oe_n) |-> low_cnt >= DEBOUNCE_CYC - 2)
    else $error("wake output before debounce");
  AST_HOLD_SHUTDOWN: assert property (s_drop |-> s_shut)
    else $error("rails still on after hold drop");
  AST_EXT_REG_OFF: assert property (
    s_drop |-> ##[1:4] !external_regulator_enable)
    else $error("external regulator enable stays high");
  AST_OVERTEMP: assert property (
    over_temp [*3] |-> rails_out.conv_on == 3'h0)
    else $error("converter on during overtemperature");
  AST_DISCHARGE: assert property (
    rails_out.conv_discharge == ~rails_out.conv_on)
    else $error("discharge does not mirror enable");
  AST_SOFT_ON: assert property (
    (rails_out.conv_soft & ~rails_out.conv_on) == 3'h0)
    else $error("soft start on a stopped converter");
  AST_RESET_OUT: assert property (
    $rose(reset_output_oe_n) |-> $past(reset_sense_above, 2))
    else $error("reset released without sense");
  AST_PG_RELEASE: assert property (
    $rose(power_good_output_oe_n) |-> $past(all_good, 2))
    else $error("power good released with rail low");
endmodule // power_button_sequencer_checker

bind power_button_sequencer power_button_sequencer_checker #(
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) u_chk (
  .clk_sys(clk_sys), .rst(rst), .push_button_input(push_button_input),
  .hold_on_input(hold_on_input), .over_temp(over_temp),
  .reset_sense_above(reset_sense_above), .rails_in(rails_in),
  .rails_out(rails_out), .lockout_level(lockout_level),
  .power_good_output_oe_n(power_good_output_oe_n),
  .reset_output_oe_n(reset_output_oe_n),
  .button_wake_output_oe_n(button_wake_output_oe_n),
  .external_regulator_enable(external_regulator_enable)
);

// ---- dv/power_button_sequencer_test.sv ----
`timescale 1ns/1ps
module power_button_sequencer_test;
  import pwr_seq_pkg::*;
  localparam int DEB = 20;
  localparam int LP = 400;
  localparam int PULSE = 100;
  logic clk_sys = 1'b0, rst = 1'b1, pb = 1'b1, keep = 1'b1, boot = 1'b0;
  logic ext_pwr = 1'b0, sys_ok = 1'b1, sense = 1'b0, ot = 1'b0;
  logic bl_pin = 1'b0, reg_wr = 1'b0, hold, pg_n, rs_n, wk_n, bl_on;
  logic sel_a, ext_en;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
  logic [6:0] duty;
  logic [1:0] lvl;
  rail_in_s rin = '{enable_pin: 3'h0, rail_good: 3'h5, reg_good: 2'h3};
  rail_out_s rout;
  int num_errors = 0, cmp_count = 0, cyc = 0, n;

  power_button_sequencer #(.DEBOUNCE_CYC(DEB), .LONG_PRESS_CYC(LP),
    .PG_DELAY_CYC(4), .START_WAIT_CYC(4), .SOFT_RAMP_CYC(8),
    .PULSE_LEN_CYC(PULSE)) u_power_button_sequencer (
    .clk_sys(clk_sys), .rst(rst), .push_button_input(pb),
    .hold_on_input(hold), .ext_power_present(ext_pwr),
    .system_rail_ok(sys_ok), .reset_sense_above(sense), .over_temp(ot),
    .backlight_enable_pin(bl_pin), .rails_in(rin), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .rails_out(rout), .lockout_level(lvl), .power_good_output_oe_n(pg_n),
    .reset_output_oe_n(rs_n), .button_wake_output_oe_n(wk_n),
    .backlight_on(bl_on), .dimming_duty(duty),
    .current_set_select_a(sel_a), .external_regulator_enable(ext_en));
  proc_model u_proc_model (.clk_sys(clk_sys), .rst(rst),
    .button_wake_output_oe_n(wk_n), .keep_on(keep), .boot_req(boot),
    .hold_on_input(hold));

  // ---------------------------------------------------------------
  // clock, watchdog and helpers
  // ---------------------------------------------------------------
  initial forever #2.5 clk_sys = ~clk_sys;
  // short test timings keep the run near 1.1k cycles; ceiling has headroom
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  // read data is combinational, so sample just after the address lands
  task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    #1 chk(nm, e, rdata);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? wk_n : s == 1 ? pg_n : rs_n;
  endfunction
  task await(input string nm, input int s, input logic v, input int lim);
    for (n = 0; n < lim && sig(s) !== v; n++) @(negedge clk_sys);
    chk(nm, {7'h0, v}, {7'h0, sig(s)});
  endtask
  task await_state(input string nm, input logic [2:0] st, input int lim);
    @(negedge clk_sys);
    reg_addr = STATUS_ADDR;
    for (n = 0; n < lim && rdata[2:0] !== st; n++) @(negedge clk_sys);
    chk(nm, {5'h0, st}, {5'h0, rdata[2:0]});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    rchk("seq", SEQ_CTRL_ADDR, SEQ_CTRL_RST);
    rchk("start", REG_START_ADDR, REG_START_RST);
    rchk("lockout", LOCKOUT_ADDR, LOCKOUT_RST);
    rchk("mask", PG_MASK_ADDR, PG_MASK_RST);
    rchk("bl_b", BL_B_ADDR, BL_B_RST);
    chk("level", 8'h00, {6'h0, lvl});
    pb = 1'b0;
    repeat (DEB - 5) @(negedge clk_sys);
    chk("wake early", 8'h01, {7'h0, wk_n});
    await("wake", 0, 1'b0, 20);
    await_state("on", ST_ON, 1000);
    chk("seq conv", 8'h07, {5'h0, rout.conv_on});
    chk("ext reg on", 8'h01, {7'h0, ext_en});
    repeat (30) @(negedge clk_sys);
    chk("pg rail low", 8'h00, {7'h0, pg_n});
    rin.rail_good = 3'h7;
    await("pg", 1, 1'b1, 200);
    sense = 1'b1;
    await("reset out", 2, 1'b1, 200);
    pb = 1'b1;
    repeat (20) @(negedge clk_sys);
    await_state("held on", ST_ON, 1);
    bl_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("bl pin", 8'h01, {7'h0, bl_on});
    chk("duty pin", {1'b0, DUTY_PIN_DEFAULT}, {1'b0, duty});
    bl_pin = 1'b0;
    wr(BL_A_ADDR, 8'h01);
    chk("bl bit", 8'h01, {7'h0, bl_on});
    wr(BL_B_ADDR, 8'hc0);
    chk("duty", 8'h40, {1'b0, duty});
    chk("set a", 8'h01, {7'h0, sel_a});
    wr(8'h20, 8'h5a);
    rchk("unmapped", 8'h20, 8'h00);
    wr(SEQ_CTRL_ADDR, 8'h38);
    chk("reg on", 8'h03, {6'h0, rout.reg_on});
    chk("follow", 8'h01, {7'h0, rout.second_follow});
    rin.enable_pin = 3'h5;
    wr(SEQ_CTRL_ADDR, 8'h3d);
    chk("pin mode", 8'h05, {5'h0, rout.conv_on});
    ot = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("hot", 8'h00, {5'h0, rout.conv_on});
    ot = 1'b0;
    pb = 1'b0;
    await("pulse", 1, 1'b0, LP + DEB + 50);
    repeat (2) @(negedge clk_sys);
    rchk("restore", BL_B_ADDR, BL_B_RST);
    repeat (PULSE - 20) @(negedge clk_sys);
    chk("pulse held", 8'h00, {7'h0, pg_n});
    await("pulse end", 1, 1'b1, 200);
    repeat (300) @(negedge clk_sys);
    chk("once", 8'h01, {7'h0, pg_n});
    pb = 1'b1;
    repeat (10) @(negedge clk_sys);
    keep = 1'b0;
    repeat (10) @(negedge clk_sys);
    await_state("off", ST_OFF, 1);
    chk("ext reg", 8'h00, {7'h0, ext_en});
    ext_pwr = 1'b1;
    keep = 1'b1;
    boot = 1'b1;
    await_state("on again", ST_ON, 1000);
    give_verdict();
  end
endmodule // power_button_sequencer_test

// ---- dv/proc_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// processor model
// ---------------------------------------------------------------
module proc_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic button_wake_output_oe_n,
  input wire logic keep_on,
  input wire logic boot_req,
  output logic hold_on_input
);
  logic raise;
  // latch on the wake strobe, long before the button comes back up
  assign raise = hold_on_input | boot_req | !button_wake_output_oe_n;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_on_input <= 1'b0;
    end else begin
      hold_on_input <= keep_on & raise;
    end
  end
endmodule // proc_model

// ---- include/pwr_seq_pkg.sv ----
package pwr_seq_pkg;
  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] SEQ_CTRL_ADDR = 8'h0d;
  localparam logic [7:0] REG_START_ADDR = 8'h16;
  localparam logic [7:0] LOCKOUT_ADDR = 8'h0e;
  localparam logic [7:0] PG_MASK_ADDR = 8'h0f;
  localparam logic [7:0] BL_A_ADDR = 8'h10;
  localparam logic [7:0] BL_B_ADDR = 8'h11;
  localparam logic [7:0] STATUS_ADDR = 8'h12;
  localparam logic [7:0] PG_DELAY_ADDR = 8'h13;

  // reset values
  localparam logic [7:0] SEQ_CTRL_RST = 8'h00;
  localparam logic [7:0] REG_START_RST = 8'h00;
  localparam logic [7:0] LOCKOUT_RST = 8'h00; // 3 V falling, 500 mV hyst
  localparam logic [7:0] PG_MASK_RST = 8'h1f;
  localparam logic [7:0] BL_A_RST = 8'h00;
  localparam logic [7:0] BL_B_RST = 8'h00;
  localparam logic [7:0] PG_DELAY_RST = 8'h01;
  localparam logic [6:0] DUTY_PIN_DEFAULT = 7'h1e; // 30 percent

  // field positions
  localparam int SQ_LSB = 0; // converter_sequence_select [2:0]
  localparam int FIRST_REG_ON = 3;
  localparam int SECOND_REG_ON = 4;
  localparam int SECOND_FOLLOW = 5;
  localparam int SINK_EN = 0; // backlight_control_a
  localparam int CUR_LEVEL = 7; // backlight_control_b

  localparam logic [2:0] SQ_PINS = 3'h5;

  // timing at 200 MHz
  localparam int CLK_MHZ = 200;
  localparam int DEBOUNCE_MS = 50;
  localparam int LONG_PRESS_S = 15;
  localparam int PG_PULSE_US = 500;
  localparam int SOFT_START_US = 250;
  localparam int STARTUP_US = 100;
  localparam int PG_DELAY_UNIT_US = 1000;
  localparam int PULSE_CYC = PG_PULSE_US * CLK_MHZ;
  localparam int SOFT_CYC = SOFT_START_US * CLK_MHZ;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int DELAY_UNIT_CYC = PG_DELAY_UNIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP_SYS, ST_LOAD, ST_START, ST_ON
  } pwr_state_e;

  typedef struct packed {
    logic [2:0] enable_pin;
    logic [2:0] rail_good;
    logic [1:0] reg_good;
  } rail_in_s;

  typedef struct packed {
    logic [2:0] conv_on;
    logic [2:0] conv_soft;
    logic [2:0] conv_discharge;
    logic [1:0] reg_on;
    logic second_follow;
  } rail_out_s;
endpackage

// ---- rtl/power_button_sequencer.sv ----
`timescale 1ns/1ps
module power_button_sequencer #(
  parameter int DEBOUNCE_CYC = pwr_seq_pkg::DEBOUNCE_MS * 1000 *
    pwr_seq_pkg::CLK_MHZ,
  parameter longint LONG_PRESS_CYC = longint'(pwr_seq_pkg::LONG_PRESS_S) *
    64'd1000000 * pwr_seq_pkg::CLK_MHZ,
  parameter int PG_DELAY_CYC = pwr_seq_pkg::DELAY_UNIT_CYC,
  parameter int START_WAIT_CYC = pwr_seq_pkg::STARTUP_CYC,
  parameter int SOFT_RAMP_CYC = pwr_seq_pkg::SOFT_CYC,
  parameter int PULSE_LEN_CYC = pwr_seq_pkg::PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push_button_input,
  input wire logic hold_on_input,
  input wire logic ext_power_present,
  input wire logic system_rail_ok,
  input wire logic reset_sense_above,
  input wire logic over_temp,
  input wire logic backlight_enable_pin,
  input wire pwr_seq_pkg::rail_in_s rails_in,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output pwr_seq_pkg::rail_out_s rails_out,
  output logic [1:0] lockout_level,
  output logic power_good_output_oe_n,
  output logic reset_output_oe_n,
  output logic button_wake_output_oe_n,
  output logic backlight_on,
  output logic [6:0] dimming_duty,
  output logic current_set_select_a,
  output logic external_regulator_enable
);
  import pwr_seq_pkg::*;

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [7:0] seq_ctrl_q, reg_start_q, lockout_q, pg_mask_q;
  logic [7:0] bl_a_q, bl_b_q, pg_delay_q;
  logic long_fire;
  logic go_off;

  // long press and power-down both restore defaults
  wire restore_defaults = long_fire || go_off;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_ctrl_q <= SEQ_CTRL_RST;
      reg_start_q <= REG_START_RST;
      lockout_q <= LOCKOUT_RST;
      pg_mask_q <= PG_MASK_RST;
      bl_a_q <= BL_A_RST;
      bl_b_q <= BL_B_RST;
      pg_delay_q <= PG_DELAY_RST;
    end else if (restore_defaults) begin
      seq_ctrl_q <= SEQ_CTRL_RST;
      reg_start_q <= REG_START_RST;
      lockout_q <= LOCKOUT_RST;
      pg_mask_q <= PG_MASK_RST;
      bl_a_q <= BL_A_RST;
      bl_b_q <= BL_B_RST;
      pg_delay_q <= PG_DELAY_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        SEQ_CTRL_ADDR: seq_ctrl_q <= reg_wdata;
        REG_START_ADDR: reg_start_q <= reg_wdata;
        LOCKOUT_ADDR: lockout_q <= reg_wdata;
        PG_MASK_ADDR: pg_mask_q <= reg_wdata;
        BL_A_ADDR: bl_a_q <= reg_wdata;
        BL_B_ADDR: bl_b_q <= reg_wdata;
        PG_DELAY_ADDR: pg_delay_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // debounce and long press
  // ---------------------------------------------------------------------
  logic btn_last_q, pressed_q, long_done_q, hold_last_q;
  logic [31:0] deb_cnt_q;
  logic [35:0] long_cnt_q;
  logic [31:0] pulse_cnt_q;

  // count restarts on any edge, so bounce cannot accumulate
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btn_last_q <= 1'b1;
      hold_last_q <= 1'b0;
      deb_cnt_q <= '0;
      pressed_q <= 1'b0;
    end else begin
      btn_last_q <= push_button_input;
      hold_last_q <= hold_on_input;
      if (push_button_input != btn_last_q) begin
        deb_cnt_q <= '0;
      end else if (deb_cnt_q < 32'(DEBOUNCE_CYC)) begin
        deb_cnt_q <= deb_cnt_q + 32'h1;
      end else begin
        pressed_q <= ~push_button_input;
      end
    end
  end

  assign long_fire = pressed_q && !long_done_q &&
                     long_cnt_q >= 36'(LONG_PRESS_CYC);

  // one pulse per press; re-armed on release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      long_cnt_q <= '0;
      long_done_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else begin
      if (!pressed_q) begin
        long_cnt_q <= '0;
        long_done_q <= 1'b0;
      end else if (long_fire) begin
        long_done_q <= 1'b1;
      end else if (!long_done_q) begin
        long_cnt_q <= long_cnt_q + 36'h1;
      end
      if (long_fire) begin
        pulse_cnt_q <= 32'(PULSE_LEN_CYC);
      end else if (pulse_cnt_q != '0) begin
        pulse_cnt_q <= pulse_cnt_q - 32'h1;
      end
    end
  end

  // debounced press still confirmed by the pin; release is prompt
  wire btn_low = pressed_q && !btn_last_q;
  // open drain: released as soon as the button comes back up
  assign button_wake_output_oe_n = ~btn_low;

  // ---------------------------------------------------------------------
  // on/off state machine
  // ---------------------------------------------------------------------
  pwr_state_e state_q;
  logic [31:0] st_cnt_q;
  logic [2:0] step_q;

  // a release still inside its debounce must not restart the device
  wire turn_on = (btn_low || (hold_on_input && ext_power_present))
                 && system_rail_ok;
  // releases without hold and lockout drop power; hold low is immediate
  assign go_off = state_q != ST_OFF &&
                  (!system_rail_ok ||
                   (!pressed_q && !hold_on_input) ||
                   (hold_last_q && !hold_on_input));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_OFF;
      st_cnt_q <= '0;
      step_q <= '0;
    end else if (go_off) begin
      state_q <= ST_OFF;
      st_cnt_q <= '0;
      step_q <= '0;
    end else begin
      unique case (state_q)
        ST_OFF: if (turn_on) begin
          state_q <= ST_RAMP_SYS;
        end
        ST_RAMP_SYS: if (system_rail_ok) begin
          state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          state_q <= ST_START; // defaults reloaded on last off
          st_cnt_q <= '0;
        end
        ST_START: begin
          // step through sequence: startup time then soft start each
          if (st_cnt_q < 32'(START_WAIT_CYC + SOFT_RAMP_CYC)) begin
            st_cnt_q <= st_cnt_q + 32'h1;
          end else if (step_q == 3'h4) begin
            state_q <= ST_ON;
          end else begin
            step_q <= step_q + 3'h1;
            st_cnt_q <= '0;
          end
        end
        ST_ON: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // rail gating
  // ---------------------------------------------------------------------
  wire on_state = state_q == ST_START || state_q == ST_ON;
  wire [2:0] sq = seq_ctrl_q[SQ_LSB +: 3];
  wire pin_mode = sq == SQ_PINS;
  wire ramping = state_q == ST_START && st_cnt_q >= 32'(START_WAIT_CYC);

  // sequence order: converter n starts at step n+1 (reversed if sq[0])
  function automatic logic seq_reached(input logic [2:0] idx);
    logic [2:0] pos;
    pos = sq[0] ? 3'(3'h2 - idx) : idx;
    return state_q == ST_ON || step_q > pos;
  endfunction

  logic [2:0] conv_en;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      conv_en[i] = on_state && !over_temp &&
                   (pin_mode ? rails_in.enable_pin[i]
                             : seq_reached(3'(i)));
    end
  end

  assign rails_out.conv_on = conv_en;
  assign rails_out.conv_soft = conv_en & {3{ramping}};
  assign rails_out.conv_discharge = ~conv_en;
  // regulators: own bit or auto start, first with the last converter, second one step after
  assign rails_out.reg_on[0] = on_state && (seq_ctrl_q[FIRST_REG_ON] ||
    (reg_start_q[0] && step_q >= 3'h3) || state_q == ST_ON &&
    reg_start_q[0]);
  assign rails_out.reg_on[1] = on_state && (seq_ctrl_q[SECOND_REG_ON] ||
    (reg_start_q[1] && step_q >= 3'h4) || state_q == ST_ON &&
    reg_start_q[1]);
  assign rails_out.second_follow = seq_ctrl_q[SECOND_FOLLOW];
  assign lockout_level = lockout_q[1:0];

  // ---------------------------------------------------------------------
  // power-good and reset delay
  // ---------------------------------------------------------------------
  wire [4:0] good = {rails_in.reg_good, rails_in.rail_good};
  wire rails_ok = on_state && ((~good & pg_mask_q[4:0]) == 5'h0);
  logic [39:0] pg_cnt_q, rs_cnt_q;
  logic pg_q, rs_q, ext_q;
  wire [39:0] delay_cyc = 40'(pg_delay_q) * 40'(PG_DELAY_CYC);

  // shared delay for power-good and reset comparator
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pg_cnt_q <= '0;
      rs_cnt_q <= '0;
      pg_q <= 1'b0;
      rs_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      if (!rails_ok) begin
        pg_cnt_q <= '0;
        pg_q <= 1'b0;
      end else if (pg_cnt_q < delay_cyc) begin
        pg_cnt_q <= pg_cnt_q + 40'h1;
      end else begin
        pg_q <= 1'b1;
      end
      if (!on_state || !reset_sense_above) begin
        rs_cnt_q <= '0;
        rs_q <= 1'b0;
      end else if (rs_cnt_q < delay_cyc) begin
        rs_cnt_q <= rs_cnt_q + 40'h1;
      end else begin
        rs_q <= 1'b1;
      end
      if (state_q == ST_OFF) begin
        ext_q <= 1'b0;
      end else if (state_q == ST_START && step_q >= sq) begin
        ext_q <= 1'b1;
      end
    end
  end

  assign power_good_output_oe_n = pg_q && pulse_cnt_q == '0;
  assign reset_output_oe_n = rs_q;
  assign external_regulator_enable = ext_q;

  // ---------------------------------------------------------------------
  // backlight
  // ---------------------------------------------------------------------
  assign backlight_on = on_state &&
                        (backlight_enable_pin || bl_a_q[SINK_EN]);
  assign dimming_duty = (backlight_enable_pin && !bl_a_q[SINK_EN]) ?
                        DUTY_PIN_DEFAULT : bl_b_q[6:0];
  assign current_set_select_a = bl_b_q[CUR_LEVEL];

  // ---------------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------------
  wire [7:0] status = {pg_q, rs_q, pressed_q, over_temp, 1'b0,
                       state_q};
  assign reg_rdata =
    reg_addr == SEQ_CTRL_ADDR ? seq_ctrl_q :
    reg_addr == REG_START_ADDR ? reg_start_q :
    reg_addr == LOCKOUT_ADDR ? lockout_q :
    reg_addr == PG_MASK_ADDR ? pg_mask_q :
    reg_addr == BL_A_ADDR ? bl_a_q :
    reg_addr == BL_B_ADDR ? bl_b_q :
    reg_addr == PG_DELAY_ADDR ? pg_delay_q :
    reg_addr == STATUS_ADDR ? status : 8'h00;
endmodule // power_button_sequencer
